// file: hdl/flu_framer.sv
// Framing user interface: transmit framer and receive deframer
//
// Behaviour
// - Transmit takes a user word only on a clock edge with ready and valid high.
// - Valid low ignores the input; inside a frame idles go out instead.
// - A word taken outside a frame opens a new frame as its first payload word.
// - Keep gives the valid byte count of the final word, read only with last.
// - Each frame gets a start set before and a stop set after its data.
// - Idle code groups fill every position without user data.
// - Odd byte counts get a pad character to complete the final code group.
// - The last two bytes of each non-final word are held and sent first next beat.
// - After a last word ready drops one cycle to send held bytes and stop set.
// - The transmitter interrupts data flow by itself for clock compensation.
// - Compensation recurs every 5000 clocks, sends six compensation beats and holds ready low for seven clocks.
// - Most significant byte of a word goes out first and is received first.
// - Receiver strips idles, compensation, start and stop sets, assembles words.
// - Receive side has no buffer and no ready input.
// - Receive valid rises with the first word; last rises with the final word.
// - Receive keep gives valid bytes of the final word, defined with last.
// - Receive valid may drop in any cycle, even mid-frame.
// - On a user pause the held bytes still go out on lane 0, idles after.
// - Compensation has no effect before channel up and starts right after.
`timescale 1ns/10ps
module flu_framer
  import flu_pkg::*;
#(
  parameter int CC_PERIOD = CC_PERIOD_DEF
)
(
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rstn,
  // Channel status from lane logic
  input  wire logic           channel_up,
  // Transmit user port
  input  wire flu_user_word_t tx_user,
  output logic                tx_ready,
  // Channel beats, byte 0 in the top bits
  output flu_beat_t           lane_tx,
  input  wire flu_beat_t      lane_rx,
  // Receive user port
  output flu_user_word_t      rx_user
);

  localparam logic [CC_TIMER_W-1:0] CC_LAST = CC_TIMER_W'(CC_PERIOD - 1);

  flu_state_t st;
  flu_state_t next_st;

  // Number of valid bytes in a final word, keep filled from the top byte
  function automatic logic [2:0] byte_count(input logic [WORD_BYTES-1:0] keep);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < WORD_BYTES; i++)
    begin
      n = n + {2'h0, keep[i]};
    end
    return n;
  endfunction : byte_count

  function automatic logic [WORD_BYTES-1:0] keep_mask(input logic [3:0] n);
    logic [WORD_BYTES-1:0] m;
    m = 4'hf;
    if (n < 4'h4)
    begin
      m = ~(4'hf >> n);
    end
    return m;
  endfunction : keep_mask

  always_comb
  begin
    logic                  take;
    logic [2:0]            n;
    logic [PAIR_W-1:0]     pre;
    logic [1:0]            pre_ctl;
    logic [BYTE_W-1:0]     b;
    logic [ACC_W-1:0]      acc;
    logic [3:0]            cnt;
    logic                  inf;
    logic                  endf;
    take    = st.tx_ready && tx_user.valid;
    n       = tx_user.last ? byte_count(tx_user.keep) : 3'h4;
    pre     = {CH_IDLE, CH_IDLE};
    pre_ctl = 2'b11;
    b       = '0;
    acc     = st.rx_acc;
    cnt     = st.rx_cnt;
    inf     = st.rx_in_frame;
    endf    = 1'b0;
    next_st = st;
    next_st.tx_beat = '{ctl: 4'hf, data: {CH_IDLE, CH_IDLE, CH_IDLE, CH_IDLE}};
    next_st.rx_out  = '0;

    // Code group in front of the new word: start set, held bytes, or idles
    if (!st.in_frame)
    begin
      pre = {CH_SCP1, CH_SCP2};
    end
    else if (st.hold_vld)
    begin
      pre     = st.hold;
      pre_ctl = 2'b00;
    end

    // Transmit path
    if (take)
    begin
      // Frame starts only on an accepted word; nothing else opens a frame
      next_st.in_frame = 1'b1;
      next_st.tx_beat.data = {pre, tx_user.data[DATA_W-1 -: PAIR_W]};
      next_st.tx_beat.ctl  = {pre_ctl, 2'b00};
      if (n == 3'h1)
      begin
        next_st.tx_beat.data[BYTE_W-1:0] = CH_PAD;
        next_st.tx_beat.ctl[0]           = 1'b1;
      end
      if (!tx_user.last)
      begin
        next_st.hold     = tx_user.data[PAIR_W-1:0];
        next_st.hold_vld = 1'b1;
      end
      else
      begin
        next_st.hold_vld = 1'b0;
        next_st.end_gap  = 1'b1;
        next_st.tail     = {CH_IDLE, CH_IDLE};
        next_st.tail_ctl = 2'b11;
        if (n == 3'h4)
        begin
          next_st.tail     = tx_user.data[PAIR_W-1:0];
          next_st.tail_ctl = 2'b00;
        end
        else if (n == 3'h3)
        begin
          next_st.tail     = {tx_user.data[PAIR_W-1 -: BYTE_W], CH_PAD};
          next_st.tail_ctl = 2'b01;
        end
      end
    end
    else if (st.end_gap)
    begin
      // Ready is low here, so the gap carries the tail and the stop set
      next_st.tx_beat.data = {st.tail, CH_ECP1, CH_ECP2};
      next_st.tx_beat.ctl  = {st.tail_ctl, 2'b11};
      next_st.end_gap      = 1'b0;
      next_st.in_frame     = 1'b0;
    end
    else if (st.hold_vld)
    begin
      next_st.tx_beat.data = {st.hold, CH_IDLE, CH_IDLE};
      next_st.tx_beat.ctl  = 4'b0011;
      next_st.hold_vld     = 1'b0;
    end
    else if (st.cc_pend || st.cc_left != 3'h0)
    begin
      // Held bytes are flushed first so compensation never splits a code group
      next_st.tx_beat.data = {CH_CC, CH_CC, CH_CC, CH_CC};
      if (st.cc_left == 3'h0)
      begin
        next_st.cc_left = CC_CYCLES - 3'h1;
        next_st.cc_pend = 1'b0;
      end
      else
      begin
        next_st.cc_left = st.cc_left - 3'h1;
      end
    end

    // Compensation timer
    if (st.cc_timer == CC_LAST)
    begin
      next_st.cc_timer = '0;
      next_st.cc_pend  = 1'b1;
    end
    else
    begin
      next_st.cc_timer = st.cc_timer + 1'b1;
    end

    // The last compensation beat is still on the channel, so ready waits one more cycle
    next_st.tx_ready = !next_st.end_gap && !next_st.cc_pend && (next_st.cc_left == 3'h0) &&
                       (st.cc_left == 3'h0);

    // Receive path: strip control bytes, left-align data into the accumulator
    for (int i = 0; i < WORD_BYTES; i++)
    begin
      b = lane_rx.data[DATA_W-1-BYTE_W*i -: BYTE_W];
      if (lane_rx.ctl[WORD_BYTES-1-i])
      begin
        if (b == CH_SCP1 && !endf)
        begin
          inf = 1'b1;
        end
        else if (b == CH_ECP1 && inf)
        begin
          inf  = 1'b0;
          endf = 1'b1;
        end
      end
      else if (inf && cnt < 4'(ACC_BYTES))
      begin
        acc[ACC_W-1-BYTE_W*int'(cnt) -: BYTE_W] = b;
        cnt = cnt + 4'h1;
      end
    end
    next_st.rx_in_frame = inf;

    // No ready from the user: each word is offered once, valid may gap anywhere
    if (st.lst_pend)
    begin
      next_st.rx_out   = '{valid: 1'b1, last: 1'b1, keep: st.lst_keep, data: st.lst_data};
      next_st.lst_pend = 1'b0;
    end
    else if (endf && cnt != 4'h0)
    begin
      if (cnt > 4'(WORD_BYTES))
      begin
        next_st.rx_out   = '{valid: 1'b1, last: 1'b0, keep: 4'hf, data: acc[ACC_W-1 -: DATA_W]};
        next_st.lst_data = acc[DATA_W-1:0];
        next_st.lst_keep = keep_mask(cnt - 4'h4);
        next_st.lst_pend = 1'b1;
      end
      else
      begin
        next_st.rx_out = '{valid: 1'b1, last: 1'b1, keep: keep_mask(cnt), data: acc[ACC_W-1 -: DATA_W]};
      end
      acc = '0;
      cnt = 4'h0;
    end
    else if (cnt > 4'(WORD_BYTES))
    begin
      // A full word waits for a fifth byte so the final word can carry last
      next_st.rx_out = '{valid: 1'b1, last: 1'b0, keep: 4'hf, data: acc[ACC_W-1 -: DATA_W]};
      acc = acc << DATA_W;
      cnt = cnt - 4'h4;
    end
    next_st.rx_acc = acc;
    next_st.rx_cnt = cnt;

    // Nothing runs before channel up; compensation timing starts at channel up
    if (!channel_up)
    begin
      next_st         = '0;
      next_st.tx_beat = '{ctl: 4'hf, data: {CH_IDLE, CH_IDLE, CH_IDLE, CH_IDLE}};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tx_ready = st.tx_ready;
  assign lane_tx  = st.tx_beat;
  assign rx_user  = st.rx_out;

endmodule : flu_framer

// file: hdl/flu_pkg.sv
// Shared types and constants for the framed lane user interface
package flu_pkg;

  // Channel geometry: two lanes of two bytes, one 32-bit user word per clock
  localparam int BYTE_W     = 8;
  localparam int WORD_BYTES = 4;
  localparam int DATA_W     = WORD_BYTES * BYTE_W;
  localparam int PAIR_W     = 2 * BYTE_W;
  localparam int ACC_BYTES  = 2 * WORD_BYTES;
  localparam int ACC_W      = ACC_BYTES * BYTE_W;

  // Control character codes (ctl flag set on the byte)
  localparam logic [7:0] CH_IDLE = 8'hbc;
  localparam logic [7:0] CH_SCP1 = 8'h5c;
  localparam logic [7:0] CH_SCP2 = 8'hfb;
  localparam logic [7:0] CH_ECP1 = 8'hfd;
  localparam logic [7:0] CH_ECP2 = 8'hfe;
  localparam logic [7:0] CH_PAD  = 8'h9c;
  localparam logic [7:0] CH_CC   = 8'hf7;

  // Clock compensation with two-byte lanes
  localparam int         CC_PERIOD_DEF = 5000;
  localparam int         CC_TIMER_W    = 13;
  localparam logic [2:0] CC_CYCLES     = 3'h6;

  typedef struct packed {
    logic                  valid;
    logic                  last;
    logic [WORD_BYTES-1:0] keep;
    logic [DATA_W-1:0]     data;
  } flu_user_word_t;

  typedef struct packed {
    logic [WORD_BYTES-1:0] ctl;
    logic [DATA_W-1:0]     data;
  } flu_beat_t;

  typedef struct packed {
    // Transmit side
    logic                  tx_ready;
    flu_beat_t             tx_beat;
    logic                  in_frame;
    logic                  hold_vld;
    logic [PAIR_W-1:0]     hold;
    logic                  end_gap;
    logic [PAIR_W-1:0]     tail;
    logic [1:0]            tail_ctl;
    logic [CC_TIMER_W-1:0] cc_timer;
    logic                  cc_pend;
    logic [2:0]            cc_left;
    // Receive side
    flu_user_word_t        rx_out;
    logic                  rx_in_frame;
    logic [ACC_W-1:0]      rx_acc;
    logic [3:0]            rx_cnt;
    logic                  lst_pend;
    logic [DATA_W-1:0]     lst_data;
    logic [WORD_BYTES-1:0] lst_keep;
  } flu_state_t;

endpackage : flu_pkg

// file: tb/flu_framer_props.sv
// Concurrent checks on the framed lane user interface ports
`timescale 1ns/10ps
module flu_framer_props
  import flu_pkg::*;
#(
  parameter int CC_PERIOD = CC_PERIOD_DEF
)
(
  // Clock, reset and status
  input wire logic           clk_sys,
  input wire logic           rstn,
  input wire logic           channel_up,
  // Transmit side
  input wire flu_user_word_t tx_user,
  input wire logic           tx_ready,
  input wire flu_beat_t      lane_tx,
  // Receive side
  input wire flu_beat_t      lane_rx,
  input wire flu_user_word_t rx_user
);
  logic      in_frm;
  wire logic acc     = tx_ready && tx_user.valid;
  wire logic cc_beat = lane_tx == {4'hf, {4{CH_CC}}};

  // Tracks whether the next accepted word opens a frame
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !channel_up)
      in_frm <= 1'b0;
    else if (acc)
      in_frm <= !tx_user.last;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_ready_gap: assert property (acc && tx_user.last |=> !tx_ready)
    else $error("ready not dropped after frame end");
  a_scp_start: assert property (acc && !in_frm |=> lane_tx.ctl[3:2] == 2'b11 &&
    lane_tx.data[31:16] == {CH_SCP1, CH_SCP2} && lane_tx.data[15:8] == $past(tx_user.data[31:24]))
    else $error("start set or first byte misplaced");
  a_hold_shift: assert property (acc ##1 (acc && in_frm && (!tx_user.last || tx_user.keep[2])) |=>
    lane_tx.data == {$past(tx_user.data[15:0], 2), $past(tx_user.data[31:16])})
    else $error("held bytes not sent first");
  a_pause_lane0: assert property (acc ##1 (!tx_user.valid && in_frm) |=>
    lane_tx == {4'h3, $past(tx_user.data[15:0], 2), {2{CH_IDLE}}})
    else $error("pause beat wrong");
  a_cc_block: assert property (cc_beat |-> !tx_ready)
    else $error("ready high during compensation");
  a_cc_len: assert property ($rose(cc_beat) |-> cc_beat[*6] ##1 !cc_beat)
    else $error("compensation not six beats");
  a_down_quiet: assert property (!channel_up |=>
    !tx_ready && !rx_user.valid && lane_tx == {4'hf, {4{CH_IDLE}}})
    else $error("activity while channel down");
  a_rx_stop: assert property (channel_up && lane_rx.ctl[1:0] == 2'b11 &&
    lane_rx.data[15:0] == {CH_ECP1, CH_ECP2} |-> ##[1:3] (rx_user.valid && rx_user.last))
    else $error("no receive last after stop set");
  a_pad_odd: assert property (acc && tx_user.last && tx_user.keep == 4'h8 |=>
    lane_tx.ctl[0] && lane_tx.data[7:0] == CH_PAD)
    else $error("pad missing");

  c_frame_end: cover property (acc && tx_user.last);
  c_cc: cover property ($rose(cc_beat));
  c_rx_last: cover property (rx_user.valid && rx_user.last);
endmodule : flu_framer_props

bind flu_framer flu_framer_props #(.CC_PERIOD(CC_PERIOD)) u_flu_framer_props (.clk_sys(clk_sys), .rstn(rstn),
  .channel_up(channel_up), .tx_user(tx_user), .tx_ready(tx_ready), .lane_tx(lane_tx), .lane_rx(lane_rx),
  .rx_user(rx_user));

// file: tb/flu_user_model.sv
// User-side partner: offers frame words and collects received words
`timescale 1ns/10ps
module flu_user_model
  import flu_pkg::*;
(
  // Clock
  input  wire logic           clk_sys,
  // Transmit handshake
  input  wire logic           tx_ready,
  output flu_user_word_t      tx_user,
  // Receive port
  input  wire flu_user_word_t rx_user
);
  // No back-pressure exists, so every word is queued at once
  flu_user_word_t rxq [$];

  initial tx_user = '{1'b0, 1'b0, 4'h0, 32'h0};

  // Holds the word until ready is sampled high
  task automatic send(input logic [31:0] d, input logic l, input logic [3:0] k, output logic ok);
    int n;
    n = 0;
    tx_user = '{1'b1, l, l ? k : ~k, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (tx_ready !== 1'b1 && n < 20);
    ok = tx_ready === 1'b1;
    #1;
  endtask : send

  // Released lines must not keep showing the old word
  task automatic release_bus;
    tx_user = '{1'b0, 1'b0, ~tx_user.keep, ~tx_user.data};
  endtask : release_bus

  always @(posedge clk_sys)
    if (rx_user.valid === 1'b1) rxq.push_back(rx_user);
endmodule : flu_user_model

// file: tb/flu_framer_tb_top.sv
// Testbench top for the framed lane user interface, channel looped back
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("Error %0t: got %h want %h", $time, a, e); end end
module flu_framer_tb_top;
  import flu_pkg::*;
  localparam int CCP = 60;
  typedef struct packed {
    logic       pause;
    logic [3:0] keep;
    logic [3:0] c2;
    logic [31:0] d2;
    logic [3:0] c3;
    logic [31:0] d3;
  } flu_row_t;
  logic           clk_sys;
  logic           rstn;
  logic           channel_up;
  logic           tx_ready;
  logic           ok;
  flu_user_word_t tx_user;
  flu_user_word_t rx_user;
  flu_user_word_t w;
  flu_beat_t      lane_tx;
  int             fail_count;
  int             checked;
  int             n;
  flu_row_t rows [5] = '{
    '{1'b0, 4'h8, 4'h1, 32'h3344559c, 4'hf, 32'hbcbcfdfe},
    '{1'b0, 4'hc, 4'h0, 32'h33445566, 4'hf, 32'hbcbcfdfe},
    '{1'b0, 4'he, 4'h0, 32'h33445566, 4'h7, 32'h779cfdfe},
    '{1'b0, 4'hf, 4'h0, 32'h33445566, 4'h3, 32'h7788fdfe},
    '{1'b1, 4'hf, 4'hc, 32'hbcbc5566, 4'h3, 32'h7788fdfe}};

  flu_framer #(.CC_PERIOD(CCP)) u_flu_framer (.clk_sys(clk_sys), .rstn(rstn), .channel_up(channel_up),
    .tx_user(tx_user), .tx_ready(tx_ready), .lane_tx(lane_tx), .lane_rx(lane_tx), .rx_user(rx_user));
  flu_user_model u_flu_user_model (.clk_sys(clk_sys), .tx_ready(tx_ready), .tx_user(tx_user),
    .rx_user(rx_user));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask : step

  task automatic put(input logic [31:0] d, input logic l, input logic [3:0] k);
    u_flu_user_model.send(d, l, k, ok);
    `CHK(ok, 1'b1)
    if (ok !== 1'b1) wrap_up;
  endtask : put

  // Counts cycles up to the end of the next compensation burst
  task automatic wait_cc(output int cyc);
    cyc = 0;
    while (lane_tx !== {4'hf, {4{CH_CC}}} && cyc < 300)
    begin
      step;
      cyc++;
    end
    while (lane_tx === {4'hf, {4{CH_CC}}} && cyc < 300)
    begin
      step;
      cyc++;
    end
    `CHK(cyc < 300, 1'b1)
    if (cyc >= 300) wrap_up;
  endtask : wait_cc

  task automatic frame(input flu_row_t r);
    put(32'h11223344, 1'b0, 4'h0);
    `CHK(lane_tx, {4'hc, CH_SCP1, CH_SCP2, 16'h1122})
    if (r.pause)
    begin
      u_flu_user_model.release_bus;
      step;
      `CHK(lane_tx, {4'h3, 32'h3344bcbc})
    end
    put(32'h55667788, 1'b1, r.keep);
    u_flu_user_model.release_bus;
    `CHK({tx_ready, lane_tx}, {1'b0, r.c2, r.d2})
    step;
    `CHK({tx_ready, lane_tx}, {1'b1, r.c3, r.d3})
    n = 0;
    while (u_flu_user_model.rxq.size() < 2 && n < 10)
    begin
      step;
      n++;
    end
    `CHK(u_flu_user_model.rxq.size(), 2)
    if (u_flu_user_model.rxq.size() != 2) wrap_up;
    w = u_flu_user_model.rxq.pop_front();
    `CHK({w.last, w.data}, {1'b0, 32'h11223344})
    w = u_flu_user_model.rxq.pop_front();
    `CHK({w.last, w.keep, w.data[31:24]}, {1'b1, r.keep, 8'h55})
  endtask : frame

  initial
  begin
    fail_count = 0;
    checked = 0;
    rstn = 1'b0;
    channel_up = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK({tx_ready, lane_tx, rx_user.valid}, {1'b0, 36'h0, 1'b0})
    rstn = 1'b1;
    step;
    `CHK({tx_ready, lane_tx}, {1'b0, 4'hf, {4{CH_IDLE}}})
    channel_up = 1'b1;
    `CHK(tx_ready, 1'b0)
    step;
    `CHK(tx_ready, 1'b1)
    wait_cc(n);
    wait_cc(n);
    `CHK(n, CCP)
    foreach (rows[i])
    begin
      wait_cc(n);
      frame(rows[i]);
    end
    channel_up = 1'b0;
    step;
    `CHK({tx_ready, lane_tx, rx_user.valid}, {1'b0, 4'hf, {4{CH_IDLE}}, 1'b0})
    wrap_up;
  end
endmodule : flu_framer_tb_top
